// ===== hw/eac_pkg.sv
// Purpose: Shared constants and types for the EEPROM access controller
// Assumes: 10 MHz system clock, 8 MHz calibrated oscillator
// Notes:   Offsets are data-space addresses
`default_nettype none

package eac_pkg;

    // Clock rates in kHz
    localparam int CLK_KHZ = 10000;
    localparam int RC_KHZ  = 8000;

    // Data-space offsets and I/O space displacement
    localparam logic [7:0] IO_TO_DATA = 8'h20;
    localparam logic [7:0] OFS_CTRL   = 8'h3F;
    localparam logic [7:0] OFS_DATA   = 8'h40;
    localparam logic [7:0] OFS_ADRL   = 8'h41;
    localparam logic [7:0] OFS_ADRH   = 8'h42;

    // Control register bit positions
    localparam int BIT_RE    = 0;
    localparam int BIT_PE    = 1;
    localparam int BIT_MPE   = 2;
    localparam int BIT_RIE   = 3;
    localparam int BIT_PM_LO = 4;
    localparam int BIT_PM_HI = 5;

    // Storage geometry
    localparam int ADDR_W = 10;
    localparam int DEPTH  = 1024;

    // Reset and erased values
    localparam logic [7:0]        RST_DATA = 8'h00;
    localparam logic [ADDR_W-1:0] RST_ADDR = 10'h000;
    localparam logic [7:0]        ERASED   = 8'hFF;

    // Cycle counts
    localparam logic [1:0] MPE_LAST  = 2'h3;
    localparam logic [2:0] WR_STALL  = 3'h2;
    localparam logic [2:0] RD_STALL  = 3'h4;

    // Programming times, oscillator ticks (26,368 and 1.8 ms)
    localparam logic [14:0] ATOMIC_RC_CYC = 15'h6700;
    localparam int          T_SPLIT_US    = 1800;
    localparam logic [14:0] SPLIT_RC_CYC  = 15'(T_SPLIT_US * RC_KHZ / 1000);

    typedef enum logic [1:0] {
        EAC_PM_ATOMIC = 2'h0,
        EAC_PM_ERASE  = 2'h1,
        EAC_PM_WRITE  = 2'h2,
        EAC_PM_RSVD   = 2'h3
    } eac_pm_e;

    typedef enum logic {
        EAC_IDLE,
        EAC_BUSY
    } eac_state_e;

    typedef struct packed {
        logic       is_io;
        logic [7:0] addr;
        logic       we;
        logic       re;
        logic [7:0] wdata;
    } eac_bus_req_s;

endpackage

`default_nettype wire

// ===== hw/eac_top.sv
// Purpose: Processor-side access logic for a 1K byte data EEPROM
// Assumes: Register requests synchronous to clk, one per cycle
// Notes:   Programming time runs from an oscillator tick enable
`default_nettype none

module eac_top #(
    parameter logic [14:0] WR_ATOMIC_TICKS = eac_pkg::ATOMIC_RC_CYC,
    parameter logic [14:0] WR_SPLIT_TICKS  = eac_pkg::SPLIT_RC_CYC
) (
    // Clock and reset
    input  wire logic                  clk,
    input  wire logic                  rstn,
    // Register access from the core
    input  wire eac_pkg::eac_bus_req_s bus_req,
    output var  logic [7:0]            bus_rdata,
    // Core status
    input  wire logic                  global_irq_en,
    input  wire logic                  flash_selfprog_busy,
    // Core controls
    output var  logic                  ready_irq,
    output var  logic                  cpu_stall
);
    import eac_pkg::*;

    logic [7:0]        mem [DEPTH];
    eac_state_e        state;
    eac_state_e        next_state;
    logic [1:0]        mode;
    logic [1:0]        next_mode;
    logic              rie;
    logic              next_rie;
    logic              mwe;
    logic              next_mwe;
    logic [1:0]        mwe_cnt;
    logic [1:0]        next_mwe_cnt;
    logic [ADDR_W-1:0] addr;
    logic [ADDR_W-1:0] next_addr;
    logic [7:0]        data;
    logic [7:0]        next_data;
    logic [7:0]        op_data;
    logic [7:0]        next_op_data;
    logic [14:0]       op_cnt;
    logic [14:0]       next_op_cnt;
    logic [14:0]       rc_acc;
    logic [14:0]       next_rc_acc;
    logic [15:0]       rc_sum;
    logic              rc_tick;
    logic [2:0]        stall_cnt;
    logic [2:0]        next_stall_cnt;
    logic [7:0]        next_rdata;
    logic              next_irq;
    logic              next_stall;
    logic [7:0]        eff_addr;
    logic [1:0]        mode_w;
    logic              wr_ctrl;
    logic              wr_go;
    logic              rd_go;
    logic              op_done;
    logic              mem_we;
    logic [7:0]        mem_wval;
    logic              pe;

    assign pe = (state == EAC_BUSY);

    // Oscillator tick enable from a phase accumulator
    always_comb begin
        rc_sum  = {1'b0, rc_acc} + 16'(RC_KHZ);
        rc_tick = 1'b0;
        next_rc_acc = rc_sum[14:0];
        if (rc_sum >= 16'(CLK_KHZ)) begin
            rc_tick     = 1'b1;
            next_rc_acc = 15'(rc_sum - 16'(CLK_KHZ));
        end
        if (!rstn) begin
            next_rc_acc = 15'h0000;
        end
    end

    // Request decode
    always_comb begin
        eff_addr = bus_req.is_io ? 8'(bus_req.addr + IO_TO_DATA) : bus_req.addr;
        mode_w   = bus_req.wdata[BIT_PM_HI:BIT_PM_LO];
        wr_ctrl  = bus_req.we && (eff_addr == OFS_CTRL);
        wr_go    = wr_ctrl && bus_req.wdata[BIT_PE] && mwe
                   && !pe && !flash_selfprog_busy
                   && (mode_w != EAC_PM_RSVD);
        rd_go    = wr_ctrl && bus_req.wdata[BIT_RE] && !pe;
        op_done  = pe && rc_tick && (op_cnt == 15'h0000);
        mem_we   = op_done;
    end

    // Value written at the end of programming
    always_comb begin
        case (mode)
            EAC_PM_ATOMIC: mem_wval = op_data;
            EAC_PM_ERASE:  mem_wval = ERASED;
            EAC_PM_WRITE:  mem_wval = mem[addr] & op_data;
            default:       mem_wval = mem[addr];
        endcase
    end

    // Next state of control and data
    always_comb begin
        next_state     = state;
        next_mode      = mode;
        next_rie       = rie;
        next_mwe       = mwe;
        next_mwe_cnt   = mwe_cnt;
        next_addr      = addr;
        next_data      = data;
        next_op_data   = op_data;
        next_op_cnt    = op_cnt;
        next_stall_cnt = stall_cnt;
        next_rdata     = bus_rdata;
        if (stall_cnt != 3'h0) begin
            next_stall_cnt = stall_cnt - 3'h1;
        end
        if (mwe) begin
            if (mwe_cnt == 2'h0) begin
                next_mwe = 1'b0;
            end else begin
                next_mwe_cnt = mwe_cnt - 2'h1;
            end
        end
        if (wr_ctrl) begin
            next_rie = bus_req.wdata[BIT_RIE];
            if (!pe) begin
                next_mode = mode_w;
            end
            if (bus_req.wdata[BIT_MPE] && !mwe && !bus_req.wdata[BIT_PE]) begin
                next_mwe     = 1'b1;
                next_mwe_cnt = MPE_LAST;
            end
        end
        case (state)
            EAC_IDLE: begin
                if (wr_go) begin
                    next_state     = EAC_BUSY;
                    next_op_data   = data;
                    next_stall_cnt = WR_STALL;
                    if (mode_w == EAC_PM_ATOMIC) begin
                        next_op_cnt = WR_ATOMIC_TICKS - 15'h0001;
                    end else begin
                        next_op_cnt = WR_SPLIT_TICKS - 15'h0001;
                    end
                end
            end
            EAC_BUSY: begin
                if (op_done) begin
                    next_state = EAC_IDLE;
                end else if (rc_tick) begin
                    next_op_cnt = op_cnt - 15'h0001;
                end
            end
            default: next_state = EAC_IDLE;
        endcase
        if (bus_req.we && eff_addr == OFS_DATA) begin
            next_data = bus_req.wdata;
        end
        if (rd_go) begin
            next_data      = mem[addr];
            next_stall_cnt = RD_STALL;
        end
        if (bus_req.we && !pe && eff_addr == OFS_ADRL) begin
            next_addr[7:0] = bus_req.wdata;
        end
        if (bus_req.we && !pe && eff_addr == OFS_ADRH) begin
            next_addr[ADDR_W-1:8] = bus_req.wdata[1:0];
        end
        if (bus_req.re) begin
            case (eff_addr)
                OFS_CTRL: next_rdata = {2'b00, mode, rie, mwe, pe, 1'b0};
                OFS_DATA: next_rdata = data;
                OFS_ADRL: next_rdata = addr[7:0];
                OFS_ADRH: next_rdata = {6'h00, addr[ADDR_W-1:8]};
                default:  next_rdata = 8'h00;
            endcase
        end
        next_irq   = rie && global_irq_en && !pe && !flash_selfprog_busy;
        next_stall = (next_stall_cnt != 3'h0);
        if (!rstn) begin
            next_rie       = 1'b0;
            next_mwe       = 1'b0;
            next_mwe_cnt   = 2'h0;
            next_data      = RST_DATA;
            next_stall_cnt = 3'h0;
            next_stall     = 1'b0;
            next_rdata     = 8'h00;
            next_irq       = 1'b0;
            if (state == EAC_BUSY) begin
                next_state = op_done ? EAC_IDLE : EAC_BUSY;
                next_mode  = mode;
            end else begin
                next_state   = EAC_IDLE;
                next_mode    = EAC_PM_ATOMIC;
                next_op_cnt  = 15'h0000;
                next_op_data = RST_DATA;
                next_addr    = RST_ADDR;
            end
        end
    end

    always_ff @(posedge clk) begin
        state     <= next_state;
        mode      <= next_mode;
        rie       <= next_rie;
        mwe       <= next_mwe;
        mwe_cnt   <= next_mwe_cnt;
        addr      <= next_addr;
        data      <= next_data;
        op_data   <= next_op_data;
        op_cnt    <= next_op_cnt;
        rc_acc    <= next_rc_acc;
        stall_cnt <= next_stall_cnt;
        bus_rdata <= next_rdata;
        ready_irq <= next_irq;
        cpu_stall <= next_stall;
    end

    // Storage array
    always_ff @(posedge clk) begin
        if (mem_we) begin
            mem[addr] <= mem_wval;
        end
    end

    // Checks
    AST_MWE_TIMEOUT: assert property (@(posedge clk) disable iff (!rstn)
        $rose(mwe) |-> mwe [*4] ##1 !mwe)
        else $error("Master write enable not cleared after four cycles");

    AST_START_ARMED: assert property (@(posedge clk) disable iff (!rstn)
        $rose(pe) |-> $past(mwe))
        else $error("Programming started without master write enable");

    AST_NO_FLASH_START: assert property (@(posedge clk) disable iff (!rstn)
        $rose(pe) |-> !$past(flash_selfprog_busy))
        else $error("Programming started during flash self-programming");

    AST_RSVD_NO_OP: assert property (@(posedge clk) disable iff (!rstn)
        $rose(pe) |-> mode != EAC_PM_RSVD)
        else $error("Programming started in reserved mode");

    AST_MODE_HOLD: assert property (@(posedge clk) disable iff (!rstn)
        pe && $past(pe) |-> $stable(mode))
        else $error("Mode changed while strobe set");

    AST_ADDR_LOCK: assert property (@(posedge clk) disable iff (!rstn)
        pe && $past(pe) |-> $stable(addr))
        else $error("Address changed while programming");

    AST_WR_STALL: assert property (@(posedge clk) disable iff (!rstn)
        $rose(pe) |-> cpu_stall [*2] ##1 !cpu_stall)
        else $error("Write stall not two cycles");

    AST_RD_STALL: assert property (@(posedge clk) disable iff (!rstn)
        rd_go |=> cpu_stall [*4] ##1 !cpu_stall)
        else $error("Read stall not four cycles");

    AST_RD_FETCH: assert property (@(posedge clk) disable iff (!rstn)
        rd_go |=> data == mem[$past(addr)])
        else $error("Read did not fetch addressed byte");

    AST_IRQ_QUIET: assert property (@(posedge clk) disable iff (!rstn)
        ready_irq |-> $past(!pe && !flash_selfprog_busy))
        else $error("Ready interrupt during programming");

    AST_IRQ_LEVEL: assert property (@(posedge clk) disable iff (!rstn)
        rie && global_irq_en && !pe && !flash_selfprog_busy |=> ready_irq)
        else $error("Ready interrupt missing while idle");

    AST_DONE_CLEARS: assert property (@(posedge clk) disable iff (!rstn)
        op_done |=> !pe)
        else $error("Strobe not cleared at end of programming");

    AST_RESET_MODE: assert property (@(posedge clk) disable iff (!rstn)
        $past(!rstn) && !$past(pe) |-> mode == EAC_PM_ATOMIC)
        else $error("Mode not cleared by reset");

    AST_ATOMIC_VALUE: assert property (@(posedge clk) disable iff (!rstn)
        op_done && mode == EAC_PM_ATOMIC |=> mem[$past(addr)] == $past(op_data))
        else $error("Atomic write stored wrong byte");

    AST_ERASE_VALUE: assert property (@(posedge clk) disable iff (!rstn)
        op_done && mode == EAC_PM_ERASE |=> mem[$past(addr)] == ERASED)
        else $error("Erase did not leave erased byte");

    AST_WRITE_BITS: assert property (@(posedge clk) disable iff (!rstn)
        op_done && mode == EAC_PM_WRITE |=> (mem[$past(addr)] & ~$past(op_data)) == 8'h00)
        else $error("Program-only set bits outside data");

    AST_UNARMED_IGNORED: assert property (@(posedge clk) disable iff (!rstn)
        !pe && !mwe && wr_ctrl && bus_req.wdata[BIT_PE] |=> !pe)
        else $error("Strobe started programming without arming");

    AST_RD_BLOCKED: assert property (@(posedge clk) disable iff (!rstn)
        pe && wr_ctrl && bus_req.wdata[BIT_RE] |=> $stable(data))
        else $error("Read performed while programming");

    AST_IO_DATA_WRITE: assert property (@(posedge clk) disable iff (!rstn)
        bus_req.we && bus_req.is_io && bus_req.addr == 8'(OFS_DATA - IO_TO_DATA)
        |=> data == $past(bus_req.wdata))
        else $error("Short I/O address did not reach data register");

    AST_TICK_RATE: assert property (@(posedge clk) disable iff (!rstn)
        !rc_tick |=> rc_tick)
        else $error("Oscillator tick enable missing two cycles");

    COV_ATOMIC: cover property (@(posedge clk) disable iff (!rstn)
        wr_go && mode_w == EAC_PM_ATOMIC);
    COV_READ: cover property (@(posedge clk) disable iff (!rstn) rd_go);
    COV_ERASE: cover property (@(posedge clk) disable iff (!rstn)
        op_done && mode == EAC_PM_ERASE);
    COV_DONE_IRQ: cover property (@(posedge clk) disable iff (!rstn)
        op_done ##2 ready_irq);
    COV_TIMEOUT: cover property (@(posedge clk) disable iff (!rstn)
        $fell(mwe) && !pe);

endmodule // eac_top

`default_nettype wire

// ===== test/eac_core_model.sv
// Purpose: Core-side model issuing register loads and stores
// Assumes: One request per call, driven at the falling edge
// Notes:   Released address and data lines show inverted values, strobes low
`default_nettype none

module eac_core_model (
    // Clock
    input  wire logic                 clk,
    // Register bus
    output var  eac_pkg::eac_bus_req_s bus_req,
    input  wire logic [7:0]           bus_rdata
);
    import eac_pkg::*;

    initial bus_req = '0;

    // Short I/O form uses offset minus displacement
    function automatic logic [7:0] map(input logic io, input logic [7:0] ofs);
        return io ? ofs - IO_TO_DATA : ofs;
    endfunction

    // One request held across one rising edge, then released
    task automatic put(input logic io, input logic [7:0] ofs, input logic w,
                       input logic r, input logic [7:0] d);
        @(negedge clk);
        bus_req = '{io, map(io, ofs), w, r, d};
        @(negedge clk);
        bus_req = '{io, ~map(io, ofs), 1'b0, 1'b0, ~d};
    endtask

    task automatic wr(input logic io, input logic [7:0] ofs, input logic [7:0] d);
        put(io, ofs, 1'b1, 1'b0, d);
    endtask

    task automatic rd(input logic io, input logic [7:0] ofs, output logic [7:0] d);
        put(io, ofs, 1'b0, 1'b1, 8'h00);
        @(negedge clk);
        d = bus_rdata;
    endtask

    // Arm then strobe within the enable window
    task automatic arm_go(input logic [7:0] c);
        wr(1'b0, OFS_CTRL, 8'h04 | (c & 8'h38));
        wr(1'b0, OFS_CTRL, c);
    endtask
endmodule // eac_core_model

`default_nettype wire

// ===== test/eac_top_tb.sv
// Purpose: Self-checking bench for the EEPROM access controller
// Assumes: Short programming tick counts of 8 and 4
// Notes:   Stall cycles counted by a monitor
`default_nettype none

module eac_top_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import eac_pkg::*;

    logic         clk, rstn, gie, fbusy, irq, stall;
    eac_bus_req_s req;
    logic [7:0]   rdata, v;
    int           n_errors, checked, n_stall, t_a, t_s;

    eac_top #(.WR_ATOMIC_TICKS(15'h0008), .WR_SPLIT_TICKS(15'h0004)) u_dut (
        .clk(clk), .rstn(rstn), .bus_req(req), .bus_rdata(rdata),
        .global_irq_en(gie), .flash_selfprog_busy(fbusy),
        .ready_irq(irq), .cpu_stall(stall));
    eac_core_model u_core (.clk(clk), .bus_req(req), .bus_rdata(rdata));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    always @(posedge clk) if (stall === 1'b1) n_stall++;

    task automatic finish_test();
        $display("errors %0d checks %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic rd_chk(input logic [7:0] ofs, input logic [7:0] exp);
        u_core.rd(1'b0, ofs, v);
        chk(v, exp);
    endtask

    task automatic set_addr(input logic [9:0] a);
        u_core.wr(1'b1, OFS_ADRL, a[7:0]);
        u_core.wr(1'b1, OFS_ADRH, {6'h00, a[9:8]});
    endtask

    task automatic wait_idle(output int n);
        n = 0;
        repeat (40) begin
            u_core.rd(1'b0, OFS_CTRL, v);
            if (v[BIT_PE] !== 1'b1) break;
            n++;
        end
        chk(v & 8'h02, 8'h00);
    endtask

    task automatic read_byte(input logic [9:0] a, input logic [7:0] exp);
        set_addr(a);
        n_stall = 0;
        u_core.wr(1'b0, OFS_CTRL, 8'h01);
        repeat (6) @(negedge clk);
        chk(8'(n_stall), 8'h04);
        rd_chk(OFS_DATA, exp);
    endtask

    task automatic t_reset();
        rd_chk(OFS_CTRL, 8'h00);
        rd_chk(OFS_DATA, RST_DATA);
        chk({7'h00, irq}, 8'h00);
    endtask

    task automatic t_atomic();
        set_addr(10'h3FF);
        u_core.wr(1'b1, OFS_DATA, 8'hA5);
        n_stall = 0;
        u_core.arm_go(8'h02);
        rd_chk(OFS_CTRL, 8'h06);
        wait_idle(t_a);
        chk(8'(n_stall), 8'h02);
        read_byte(10'h3FF, 8'hA5);
    endtask

    task automatic t_modes();
        set_addr(10'h155);
        u_core.arm_go(8'h12);
        rd_chk(OFS_CTRL, 8'h16);
        wait_idle(t_s);
        read_byte(10'h155, ERASED);
        chk(8'(t_a > t_s), 8'h01);
        u_core.wr(1'b0, OFS_DATA, 8'h3C);
        u_core.arm_go(8'h22);
        wait_idle(t_s);
        read_byte(10'h155, 8'h3C);
        u_core.wr(1'b0, OFS_DATA, 8'h00);
        u_core.arm_go(8'h32);
        u_core.rd(1'b0, OFS_CTRL, v);
        chk(v & 8'h02, 8'h00);
        read_byte(10'h155, 8'h3C);
    endtask

    task automatic t_arm();
        u_core.wr(1'b0, OFS_CTRL, 8'h04);
        rd_chk(OFS_CTRL, 8'h04);
        repeat (4) @(negedge clk);
        rd_chk(OFS_CTRL, 8'h00);
        u_core.wr(1'b0, OFS_CTRL, 8'h02);
        rd_chk(OFS_CTRL, 8'h00);
    endtask

    task automatic t_flash();
        fbusy = 1'b1;
        u_core.arm_go(8'h0A);
        u_core.rd(1'b0, OFS_CTRL, v);
        chk(v & 8'h0A, 8'h08);
        gie = 1'b1;
        repeat (3) @(negedge clk);
        chk({7'h00, irq}, 8'h00);
        fbusy = 1'b0;
        repeat (3) @(negedge clk);
        chk({7'h00, irq}, 8'h01);
        gie = 1'b0;
        repeat (3) @(negedge clk);
        chk({7'h00, irq}, 8'h00);
    endtask

    task automatic t_busy();
        set_addr(10'h3FF);
        u_core.arm_go(8'h0A);
        gie = 1'b1;
        repeat (2) @(negedge clk);
        chk({7'h00, irq}, 8'h00);
        u_core.wr(1'b0, OFS_CTRL, 8'h28);
        u_core.wr(1'b0, OFS_ADRL, 8'h00);
        u_core.wr(1'b0, OFS_DATA, 8'h11);
        u_core.wr(1'b0, OFS_CTRL, 8'h09);
        wait_idle(t_s);
        rd_chk(OFS_CTRL, 8'h08);
        rd_chk(OFS_ADRL, 8'hFF);
        rd_chk(OFS_DATA, 8'h11);
        repeat (2) @(negedge clk);
        chk({7'h00, irq}, 8'h01);
        gie = 1'b0;
    endtask

    task automatic t_rst();
        u_core.arm_go(8'h12);
        @(negedge clk);
        rstn = 1'b0;
        @(negedge clk);
        rstn = 1'b1;
        rd_chk(OFS_CTRL, 8'h12);
        wait_idle(t_s);
        read_byte(10'h3FF, ERASED);
    endtask

    initial begin
        rstn = 1'b0;
        gie = 1'b0;
        fbusy = 1'b0;
        n_errors = 0;
        checked = 0;
        n_stall = 0;
        repeat (10) @(negedge clk);
        rstn = 1'b1;
        t_reset();
        t_atomic();
        t_modes();
        t_arm();
        t_flash();
        t_busy();
        t_rst();
        finish_test();
    end

    initial begin
        #2000000;
        n_errors++;
        $display("MISMATCH %0t watchdog expired", $time);
        finish_test();
    end
endmodule // eac_top_tb

`default_nettype wire
